// >>> rtl/trcb_pkg.sv
// timer 2 shared constants, register layout and mode encoding
// assumes a single 125 MHz clock domain and a 32-bit AXI4-Lite slave port
package trcb_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses, one aligned word each)
  // ----------------------------------------------------------------
  localparam int          ADDR_W      = 8;
  localparam logic [7:0]  ADDR_CTRL   = 8'h00;
  localparam logic [7:0]  ADDR_MODE   = 8'h04;
  localparam logic [7:0]  ADDR_COUNT  = 8'h08;
  localparam logic [7:0]  ADDR_RELOAD = 8'h0C;

  // ----------------------------------------------------------------
  // field layouts
  // ----------------------------------------------------------------
  // timer_control_reg bits 7..1, bit 0 reads as zero
  typedef struct packed {
    logic overflow_flag;
    logic external_flag;
    logic rx_clock_select;
    logic tx_clock_select;
    logic external_enable;
    logic run_bit;
    logic timer_counter_select;
  } trcb_ctrl_s;

  // timer_mode_reg bits 2..0
  typedef struct packed {
    logic irq_enable;
    logic clock_out_enable;
    logic down_count_enable;
  } trcb_mode_s;

  localparam int CTRL_LSB = 1;
  localparam int MODE_LSB = 0;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam trcb_ctrl_s  CTRL_RST   = 7'h00;
  localparam trcb_mode_s  MODE_RST   = 3'h0;
  localparam logic [15:0] COUNT_RST  = 16'h0000;
  localparam logic [15:0] RELOAD_RST = 16'h0000;

  // ----------------------------------------------------------------
  // counts
  // ----------------------------------------------------------------
  localparam logic [15:0] COUNT_MAX   = 16'hFFFF;
  localparam logic [2:0]  MACH_LAST   = 3'h5;  // six clocks per machine cycle
  localparam logic [3:0]  BAUD_LAST   = 4'hF;  // overflow rate over 16
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // counting function, one-hot
  typedef enum logic [2:0] {
    OP_RELOAD = 3'b001,
    OP_CLKOUT = 3'b010,
    OP_BAUD   = 3'b100
  } trcb_op_e;

endpackage

// >>> rtl/trcb_pin_sync.sv
// two-flop synchroniser with falling-edge detect for one pin
// assumes the pin is asynchronous to aclk
`timescale 1ns/1ps
module trcb_pin_sync (
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // pin side
  input  wire logic pin,
  // synchronised side
  output logic      level,
  output logic      fall
);

  logic meta;
  logic prev;

  // ----------------------------------------------------------------
  // synchroniser, meta read only by level
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta  <= 1'b1;
      level <= 1'b1;
      prev  <= 1'b1;
    end
    else
    begin
      meta  <= pin;
      level <= meta;
      prev  <= level;
    end
  end

  // one-cycle pulse on a high-to-low step
  assign fall = prev & ~level;

endmodule // trcb_pin_sync

// >>> rtl/trcb_timer2.sv
// timer 2: auto-reload up/down counter, clock-out and baud generator
// assumes aclk at 125 MHz, AXI4-Lite master on the same clock, async pins
// Contract
// R1 - down count off after reset, then pin direction
// R2 - up count to FFFF, flag, reload
// R3 - external edge also reloads, sets external flag
// R4 - interrupt when enabled and either flag set
// R5 - edge seen over three machine cycles
// R6 - trigger high counts up, reload on FFFF
// R7 - trigger low counts down, underflow loads FFFF
// R8 - external flag toggles on over/underflow
// R9 - clock out needs select clear, enable, run
// R10 - clock out is fosc over 2(65536-reload)
// R11 - clock-out roll-overs raise no interrupt
// R12 - tx/rx selects choose this timer or other
// R13 - baud roll-over reloads full 16 bits
// R14 - baud tick is overflow rate over 16
// R15 - internal baud clocking increments every clock
// R16 - baud mode when a select set, no flag
// R17 - baud mode edge sets flag, no reload
// R18 - software stops timer before touching counts
// R19 - reload rate is source over 65536-reload
// R20 - select picks machine cycles or pin falls
// R21 - overflow flag sticky, not in baud/clock-out
// R22 - pins synchronised, reload in same cycle
`timescale 1ns/1ps
module trcb_timer2 (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [7:0]  awaddr,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  // axi4-lite read
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [7:0]  araddr,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  // pins
  input  wire logic        trigger_pin,
  input  wire logic        count_pin_in,
  output logic             count_pin_out,
  output logic             count_pin_oe,
  // serial port and interrupt
  input  wire logic        other_timer_ovf,
  output logic [1:0]       baud_tick,
  output logic             irq
);

  trcb_pkg::trcb_ctrl_s ctrl;
  trcb_pkg::trcb_mode_s mode;
  trcb_pkg::trcb_op_e   op;
  logic [15:0] count;
  logic [15:0] reload;
  logic [15:0] next_count;
  logic [7:0]  aw_q;
  logic [31:0] wd_q;
  logic [3:0]  ws_q;
  logic [2:0]  mc_cnt;
  logic        mc_tick;
  logic        trig_lvl;
  logic        cnt_fall;
  logic        trig_s1;
  logic        trig_pend;
  logic        step;
  logic        down;
  logic        roll_up;
  logic        roll_dn;
  logic        ext_evt;
  logic        ext_reload;
  logic        wr_go;
  logic        aw_got;
  logic        w_got;
  logic        wr_ctrl;
  logic        wr_mode;
  logic        wr_count;
  logic        wr_reload;
  logic [15:0] wmask;
  logic [1:0]  clk_sel;
  logic [1:0]  baud_src;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // both pins pass two flops before any edge logic R22
  trcb_pin_sync u_trig_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin     (trigger_pin),
    .level   (trig_lvl),
    .fall    ()
  );

  trcb_pin_sync u_cnt_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin     (count_pin_in),
    .level   (),
    .fall    (cnt_fall)
  );

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  // address and data are held until both arrive, then one write cycle
  // held flags, not idle readies, so reset release starts no phantom write
  assign wr_go = aw_got & w_got & ~bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready <= 1'b0;
      wready  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= trcb_pkg::RESP_OKAY;
      aw_q    <= 8'h00;
      wd_q    <= 32'h0000_0000;
      ws_q    <= 4'h0;
      aw_got  <= 1'b0;
      w_got   <= 1'b0;
    end
    else
    begin
      if (awvalid && awready)
      begin
        awready <= 1'b0;
        aw_got  <= 1'b1;
        aw_q    <= awaddr;
      end
      if (wvalid && wready)
      begin
        wready <= 1'b0;
        w_got  <= 1'b1;
        wd_q   <= wdata;
        ws_q   <= wstrb;
      end
      if (wr_go)
      begin
        aw_got <= 1'b0;
        w_got  <= 1'b0;
        bvalid <= 1'b1;
        bresp  <= (wr_ctrl | wr_mode | wr_count | wr_reload |
                   (aw_q[7:4] == 4'h0 && aw_q[1:0] == 2'h0)) ?
                  trcb_pkg::RESP_OKAY : trcb_pkg::RESP_SLVERR;
      end
      else if (bvalid && bready)
      begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
      else if (!bvalid && !awready && !wready && !aw_got && !w_got)
      begin
        awready <= 1'b1;  // first cycle after reset
        wready  <= 1'b1;
      end
    end
  end

  // address decode of the held write
  always_comb
  begin
    wr_ctrl   = 1'b0;
    wr_mode   = 1'b0;
    wr_count  = 1'b0;
    wr_reload = 1'b0;
    if (wr_go && aw_q == trcb_pkg::ADDR_CTRL)
      wr_ctrl = 1'b1;
    else if (wr_go && aw_q == trcb_pkg::ADDR_MODE)
      wr_mode = 1'b1;
    else if (wr_go && aw_q == trcb_pkg::ADDR_COUNT)
      wr_count = 1'b1;
    else if (wr_go && aw_q == trcb_pkg::ADDR_RELOAD)
      wr_reload = 1'b1;
  end

  assign wmask = {{8{ws_q[1]}}, {8{ws_q[0]}}};

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  // data captured at the address handshake, answered one cycle later
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= trcb_pkg::RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rresp   <= trcb_pkg::RESP_OKAY;
      if (araddr == trcb_pkg::ADDR_CTRL)
        rdata <= {24'h000000, ctrl, 1'b0};
      else if (araddr == trcb_pkg::ADDR_MODE)
        rdata <= {29'h00000000, mode};
      else if (araddr == trcb_pkg::ADDR_COUNT)
        rdata <= {16'h0000, count};
      else if (araddr == trcb_pkg::ADDR_RELOAD)
        rdata <= {16'h0000, reload};
      else
      begin
        rdata <= 32'h0000_0000;
        rresp <= trcb_pkg::RESP_SLVERR;
      end
    end
    else if (rvalid && rready)
    begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
    else if (!rvalid)
      arready <= 1'b1;
  end

  // ----------------------------------------------------------------
  // machine cycle and trigger edge sampling
  // ----------------------------------------------------------------
  assign mc_tick = (mc_cnt == trcb_pkg::MACH_LAST);

  // pin sampled once per machine cycle: 1, then 0, flag in the third R5
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mc_cnt    <= 3'h0;
      trig_s1   <= 1'b1;
      trig_pend <= 1'b0;
    end
    else
    begin
      mc_cnt <= mc_tick ? 3'h0 : mc_cnt + 3'h1;
      if (mc_tick)
      begin
        trig_s1   <= trig_lvl;
        trig_pend <= trig_s1 & ~trig_lvl;  // R5
      end
    end
  end

  assign ext_evt = mc_tick & trig_pend & ctrl.external_enable;

  // ----------------------------------------------------------------
  // function select and counting step
  // ----------------------------------------------------------------
  // baud wins over clock-out; a select bit alone makes baud mode
  always_comb
  begin
    if (ctrl.tx_clock_select || ctrl.rx_clock_select)
      op = trcb_pkg::OP_BAUD;  // R16
    else if (mode.clock_out_enable && !ctrl.timer_counter_select)
      op = trcb_pkg::OP_CLKOUT;  // R9
    else
      op = trcb_pkg::OP_RELOAD;
  end

  // pin falls, every clock in baud/clock-out, else machine cycles
  always_comb
  begin
    if (!ctrl.run_bit)
      step = 1'b0;
    else if (ctrl.timer_counter_select)
      step = cnt_fall;  // R20
    else if (op != trcb_pkg::OP_RELOAD)
      step = 1'b1;  // R15
    else
      step = mc_tick;  // R19
  end

  // trigger low counts down only in up/down reload use R1
  assign down = mode.down_count_enable & ~trig_lvl & (op == trcb_pkg::OP_RELOAD);
  assign roll_up = step & ~down & (count == trcb_pkg::COUNT_MAX);  // R6
  assign roll_dn = step & down & (count == reload);  // R7
  // in up/down use the trigger is direction, so no edge reload
  assign ext_reload = ext_evt & (op == trcb_pkg::OP_RELOAD) & ~mode.down_count_enable;  // R17

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  // reload lands in the very cycle of its cause R22
  always_comb
  begin
    if (wr_count)
      next_count = (count & ~wmask) | (wd_q[15:0] & wmask);
    else if (roll_up || ext_reload)
      next_count = reload;  // R2 R3 R13
    else if (roll_dn)
      next_count = trcb_pkg::COUNT_MAX;  // R7
    else if (step && down)
      next_count = count - 16'h0001;
    else if (step)
      next_count = count + 16'h0001;
    else
      next_count = count;
  end

  // software write wins over counting; stop the timer first if it matters
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      count <= trcb_pkg::COUNT_RST;
    else
      count <= next_count;
  end

  // reload pair, software only
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      reload <= trcb_pkg::RELOAD_RST;
    else if (wr_reload)
      reload <= (reload & ~wmask) | (wd_q[15:0] & wmask);
  end

  // ----------------------------------------------------------------
  // control and mode registers
  // ----------------------------------------------------------------
  // hardware set wins over a software clear in the same cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ctrl <= trcb_pkg::CTRL_RST;
    else
    begin
      if (wr_ctrl && ws_q[0])
        ctrl <= trcb_pkg::trcb_ctrl_s'(wd_q[7:trcb_pkg::CTRL_LSB]);
      // sticky, only in plain reload use R21 R11 R16
      if ((roll_up || roll_dn) && op == trcb_pkg::OP_RELOAD)
        ctrl.overflow_flag <= 1'b1;  // R2
      if ((roll_up || roll_dn) && op == trcb_pkg::OP_RELOAD && mode.down_count_enable)
        ctrl.external_flag <= (wr_ctrl && ws_q[0]) ? ~wd_q[6] : ~ctrl.external_flag;  // R8
      else if (ext_evt && !(op == trcb_pkg::OP_RELOAD && mode.down_count_enable))
        ctrl.external_flag <= 1'b1;  // R3 R17
    end
  end

  // down count enable is clear after reset R1
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      mode <= trcb_pkg::MODE_RST;
    else if (wr_mode && ws_q[0])
      mode <= trcb_pkg::trcb_mode_s'(wd_q[2:trcb_pkg::MODE_LSB]);
  end

  // ----------------------------------------------------------------
  // interrupt and clock-out
  // ----------------------------------------------------------------
  // one request line for both flags R4
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq <= 1'b0;
    else
      irq <= mode.irq_enable & (ctrl.overflow_flag | ctrl.external_flag);
  end

  // toggle per roll-over gives half the roll-over rate, 50 % duty R10
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      count_pin_out <= 1'b0;
      count_pin_oe  <= 1'b0;
    end
    else
    begin
      count_pin_oe <= (op == trcb_pkg::OP_CLKOUT) & ctrl.run_bit;  // R9
      if (op != trcb_pkg::OP_CLKOUT)
        count_pin_out <= 1'b0;
      else if (roll_up)
        count_pin_out <= ~count_pin_out;  // R10
    end
  end

  // ----------------------------------------------------------------
  // baud ticks, index 0 transmit, 1 receive
  // ----------------------------------------------------------------
  assign clk_sel = {ctrl.rx_clock_select, ctrl.tx_clock_select};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_baud
      logic [3:0] div;
      // each direction picks its own source R12
      assign baud_src[gi] = clk_sel[gi] ? (roll_up & (op == trcb_pkg::OP_BAUD)) : other_timer_ovf;

      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          div           <= 4'h0;
          baud_tick[gi] <= 1'b0;
        end
        else
        begin
          baud_tick[gi] <= baud_src[gi] & (div == trcb_pkg::BAUD_LAST);  // R14
          if (baud_src[gi])
            div <= div + 4'h1;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_fall_seen;
    mc_tick && trig_s1 && !trig_lvl;
  endsequence

  sequence s_flag_cycle;
    trig_pend[*5] ##1 (mc_tick && trig_pend);
  endsequence

  a_reset_counts_up: assert property (@(posedge aclk) $rose(aresetn) |-> !mode.down_count_enable) // R1
    else $error("down count not clear after reset");

  a_up_overflow_reload: assert property (@(posedge aclk) disable iff (!aresetn) // R2
    (roll_up && !wr_count && !wr_reload) |=> (count == $past(reload)))
    else $error("overflow did not reload count");

  a_edge_reload: assert property (@(posedge aclk) disable iff (!aresetn) // R3
    (ext_reload && !wr_count && !wr_ctrl) |=> (count == $past(reload)) && ctrl.external_flag)
    else $error("trigger edge did not reload and flag");

  a_irq_from_flags: assert property (@(posedge aclk) disable iff (!aresetn) // R4
    ##1 (irq == $past(mode.irq_enable & (ctrl.overflow_flag | ctrl.external_flag))))
    else $error("interrupt does not follow flags");

  a_edge_three_cycles: assert property (@(posedge aclk) disable iff (!aresetn) // R5
    s_fall_seen |=> s_flag_cycle)
    else $error("trigger edge not held to third machine cycle");

  a_down_underflow: assert property (@(posedge aclk) disable iff (!aresetn) // R7
    (roll_dn && !wr_count) |=> (count == 16'hFFFF) && (ctrl.overflow_flag || $past(wr_ctrl)))
    else $error("underflow did not load all ones");

  a_ext_toggle: assert property (@(posedge aclk) disable iff (!aresetn) // R8
    ((roll_up || roll_dn) && op == trcb_pkg::OP_RELOAD && mode.down_count_enable && !wr_ctrl)
    |=> (ctrl.external_flag != $past(ctrl.external_flag)))
    else $error("external flag did not toggle");

  a_clkout_toggle: assert property (@(posedge aclk) disable iff (!aresetn) // R10
    (roll_up && op == trcb_pkg::OP_CLKOUT) |=> (count_pin_out != $past(count_pin_out)))
    else $error("clock out did not toggle on roll-over");

  a_no_flag_baud: assert property (@(posedge aclk) disable iff (!aresetn) // R16
    (op != trcb_pkg::OP_RELOAD && !wr_ctrl) |=> !$rose(ctrl.overflow_flag))
    else $error("overflow flag set outside reload use");

  a_baud_div: assert property (@(posedge aclk) disable iff (!aresetn) // R14
    (baud_src[0] && g_baud[0].div == 4'hF) |=> baud_tick[0] ##1 !baud_tick[0])
    else $error("transmit tick not every sixteenth source pulse");

endmodule // trcb_timer2

// >>> tb/trcb_pins.sv
// far-side model: trigger pin, count pin driver and other timer overflow
// assumes one shared clock; the bench resolves the count pin wire
`timescale 1ns/1ps
module trcb_pins (
  // clock
  input  wire logic aclk,
  // pins toward the timer
  output logic      trigger_pin,
  output logic      count_drv,
  output logic      other_timer_ovf
);
  // idle: lines high, no overflow pulse
  initial
  begin
    trigger_pin     = 1'b1;
    count_drv       = 1'b1;
    other_timer_ovf = 1'b0;
  end

  // level change just after a clock edge
  task set_trig(input logic v);
    @(posedge aclk);
    trigger_pin <= v;
  endtask

  // falls kept at least twelve clocks apart
  task fall_count(input int n);
    repeat (n)
    begin
      @(posedge aclk);
      count_drv <= 1'b0;
      repeat (6) @(posedge aclk);
      count_drv <= 1'b1;
      repeat (6) @(posedge aclk);
    end
  endtask

  // one-cycle pulses, one every second clock
  task pulse_other(input int n);
    repeat (n)
    begin
      @(posedge aclk);
      other_timer_ovf <= 1'b1;
      @(posedge aclk);
      other_timer_ovf <= 1'b0;
    end
  endtask
endmodule // trcb_pins

// >>> tb/timer2_reload_clockout_baud_bench.sv
// self-checking bench for the timer over its register bus and pins
// assumes trcb_timer2 and the trcb_pins far-side model
`timescale 1ns/1ps
module timer2_reload_clockout_baud_bench;
  logic        aclk = 1'b0;
  logic        aresetn;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rv;
  logic [3:0]  wstrb;
  logic        awready, wready, bvalid, arready, rvalid, irq, cnt_out, cnt_oe, cnt_drv, trig, oth;
  logic [1:0]  bresp, rresp, resp, baud_tick;
  int          n_mismatch = 0, comparisons = 0, cyc = 0, n;

  // -------------------------------------------------------------
  // clock, device, far side
  // -------------------------------------------------------------
  always #4 aclk = ~aclk;

  trcb_timer2 u_dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .trigger_pin(trig), .count_pin_in(cnt_oe ? cnt_out : cnt_drv),
    .count_pin_out(cnt_out), .count_pin_oe(cnt_oe), .other_timer_ovf(oth), .baud_tick(baud_tick), .irq(irq));

  trcb_pins u_pins (.aclk(aclk), .trigger_pin(trig), .count_drv(cnt_drv), .other_timer_ovf(oth));

  // hang guard, far above the few hundred cycles needed
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_mismatch++;
      stop_test();
    end
  end

  // -------------------------------------------------------------
  // shared tasks
  // -------------------------------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("FAIL %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  // address and data offered together, each released once taken
  task wr(input logic [7:0] a, input logic [31:0] d);
    bit ap, wp;
    @(posedge aclk);
    awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= d; wstrb <= 4'hF; bready <= 1'b1;
    ap = 1; wp = 1;
    while (ap || wp)
    begin
      @(posedge aclk);
      if (ap && awready) begin awvalid <= 1'b0; ap = 0; end
      if (wp && wready) begin wvalid <= 1'b0; wp = 0; end
    end
    while (!bvalid) @(posedge aclk);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task rd(input logic [7:0] a);
    @(posedge aclk);
    arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge aclk);
    rv = rdata; resp = rresp;
    rready <= 1'b0;
  endtask

  // clocks from one change of the clock-out pin or one transmit tick to the next
  task gap(input bit tick);
    logic lv;
    for (int k = 0; k < 2; k++)
    begin
      n = 0; lv = cnt_out;
      do begin @(posedge aclk); n++; end while ((tick ? !baud_tick[0] : cnt_out === lv) && n < 200);
    end
  endtask

  // -------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------
  task t_reset;
    rd(8'h00); check(rv, 32'h0, "control reset");
    rd(8'h04); check(rv, 32'h0, "mode reset, counts up");
    rd(8'h08); check(rv, 32'h0, "count reset");
    rd(8'h10); check(rv, 32'h0, "unmapped read data");
    check(resp, 2'h2, "unmapped read response");
    wr(8'h10, 32'hFF); check(resp, 2'h2, "unmapped write");
    $display("test reset ends");
  endtask

  task t_count_pin;
    wr(8'h0C, 32'h0); wr(8'h08, 32'h0); wr(8'h00, 32'h6);
    u_pins.fall_count(3);
    repeat (10) @(posedge aclk);
    wr(8'h00, 32'h0); rd(8'h08); check(rv, 32'h3, "count pin falls");
    $display("test count pin ends");
  endtask

  task t_up_reload;
    wr(8'h04, 32'h4); wr(8'h0C, 32'hFFF0); wr(8'h08, 32'hFFFE); wr(8'h00, 32'h4);
    n = 0;
    while (!irq && n < 100) begin @(posedge aclk); n++; end
    check(irq, 1'b1, "irq on overflow");
    wr(8'h00, 32'h80); rd(8'h00); check(rv, 32'h80, "overflow flag");
    rd(8'h08); check(rv >= 32'hFFF0 && rv <= 32'hFFF3, 1'b1, "reloaded count");
    wr(8'h00, 32'h0); rd(8'h00); check(rv, 32'h0, "flag cleared by software");
    repeat (2) @(posedge aclk);
    check(irq, 1'b0, "irq drops");
    wr(8'h04, 32'h0);
    $display("test up reload ends");
  endtask

  task t_trigger;
    wr(8'h0C, 32'hABCD); wr(8'h08, 32'h1234); wr(8'h00, 32'h8);
    u_pins.set_trig(1'b0);
    repeat (40) @(posedge aclk);
    rd(8'h08); check(rv, 32'hABCD, "edge reload");
    rd(8'h00); check(rv, 32'h48, "external flag");
    u_pins.set_trig(1'b1);
    wr(8'h00, 32'h0); wr(8'h08, 32'h1234);
    u_pins.set_trig(1'b0);
    repeat (40) @(posedge aclk);
    rd(8'h08); check(rv, 32'h1234, "edge ignored");
    rd(8'h00); check(rv, 32'h0, "no flag");
    u_pins.set_trig(1'b1);
    $display("test trigger ends");
  endtask

  task t_updown;
    int k;
    wr(8'h04, 32'h1); u_pins.set_trig(1'b0);
    wr(8'h0C, 32'h10); wr(8'h08, 32'h12); wr(8'h00, 32'h4);
    k = 0;
    do begin rd(8'h00); k++; end while (rv[7] !== 1'b1 && k < 20);
    check(rv, 32'hC4, "underflow flags");
    wr(8'h00, 32'h0); rd(8'h08); check(rv >= 32'hFFF8, 1'b1, "underflow loads top");
    u_pins.set_trig(1'b1); wr(8'h04, 32'h0);
    $display("test up down ends");
  endtask

  task t_clock_out;
    wr(8'h0C, 32'hFFFC); wr(8'h08, 32'hFFFC); wr(8'h04, 32'h6); wr(8'h00, 32'h4);
    @(posedge aclk);
    check(cnt_oe, 1'b1, "pin driven");
    gap(1'b0); check(n, 32'h4, "half period");
    rd(8'h00); check(rv, 32'h4, "no overflow flag");
    check(irq, 1'b0, "no irq");
    wr(8'h00, 32'h0); wr(8'h04, 32'h0);
    repeat (2) @(posedge aclk);
    check(cnt_oe, 1'b0, "pin released");
    $display("test clock out ends");
  endtask

  task t_baud;
    wr(8'h0C, 32'hFFFE); wr(8'h08, 32'hFFFE); wr(8'h00, 32'h1C);
    gap(1'b1); check(n, 32'h20, "transmit tick spacing");
    u_pins.set_trig(1'b0);
    repeat (40) @(posedge aclk);
    rd(8'h00); check(rv, 32'h5C, "edge flag only");
    u_pins.set_trig(1'b1);
    n = 0;
    fork
      u_pins.pulse_other(16);
      repeat (40) @(posedge aclk) n += baud_tick[1];
    join
    check(n, 32'h1, "receive tick from other timer");
    wr(8'h00, 32'h0);
    $display("test baud ends");
  endtask

  // -------------------------------------------------------------
  // closing and main sequence
  // -------------------------------------------------------------
  task stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    aresetn <= 1'b0;
    awvalid <= 1'b0;
    wvalid  <= 1'b0;
    bready  <= 1'b0;
    arvalid <= 1'b0;
    rready  <= 1'b0;
    awaddr  <= 8'h00;
    araddr  <= 8'h00;
    wdata   <= 32'h0;
    wstrb   <= 4'h0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset(); t_count_pin(); t_up_reload(); t_trigger(); t_updown(); t_clock_out(); t_baud();
    stop_test();
  end
endmodule // timer2_reload_clockout_baud_bench
